// File: mcyc_regs.svh
// register indices, field positions, reset values and cycle timing figures
`ifndef MCYC_REGS_SVH
`define MCYC_REGS_SVH
`define MCYC_IDX_CLK      8'h01
`define MCYC_IDX_MEMCFG   8'h02
`define MCYC_IDX_PWR      8'h03
`define MCYC_IDX_STAT     8'h04
`define MCYC_IDX_DISPCFG  8'h07
`define MCYC_CYC_MSB      6
`define MCYC_CYC_LSB      5
`define MCYC_CPUDIV_MSB   7
`define MCYC_CPUDIV_LSB   5
`define MCYC_IODIV_MSB    1
`define MCYC_IODIV_LSB    0
`define MCYC_W16_BIT      0
`define MCYC_MTYPE_MSB    2
`define MCYC_MTYPE_LSB    1
`define MCYC_MCLK_BIT     3
`define MCYC_PWR_MSB      1
`define MCYC_PWR_LSB      0
`define MCYC_RST_VAL      8'h00
`define MCYC_VID_DIV      4'h2
`define MCYC_PS4_DIV      4'h4
`define MCYC_PS8_DIV      4'h8
`define MCYC_CPUDIV_0     4'h2
`define MCYC_CPUDIV_1     4'h3
`define MCYC_CPUDIV_2     4'h4
`define MCYC_CPUDIV_3     4'h6
`define MCYC_CPUDIV_4     4'h8
`define MCYC_OE_START     5'h01
`define MCYC_CAS_START    5'h02
// {total, cs active, oe half periods, ras active, cas active}
`define MCYC_T_X8_FAST    {4'h3, 4'h2, 4'h3, 4'h2, 4'h1}
`define MCYC_T_X8_NORM    {4'h4, 4'h2, 4'h3, 4'h2, 4'h1}
`define MCYC_T_X8_SLOW    {4'h5, 4'h3, 4'h5, 4'h3, 4'h2}
`define MCYC_T_X16_FAST   {4'h4, 4'h3, 4'h5, 4'h2, 4'h1}
`define MCYC_T_X16_NORM   {4'h5, 4'h3, 4'h5, 4'h3, 4'h2}
`define MCYC_T_X16_SLOW   {4'h6, 4'h4, 4'h7, 4'h3, 4'h2}
`endif

// File: mcyc_pkg.sv
// types shared by the memory cycle timing block
package mcyc_pkg;
    typedef enum logic [1:0] {CYC_FAST, CYC_NORMAL, CYC_SLOW, CYC_RSVD} mcyc_cyc_t;
    typedef enum logic [1:0] {MEM_SRAM, MEM_PSRAM, MEM_DRAM, MEM_RSVD} mcyc_mem_t;
    typedef enum logic [1:0] {PWR_FULL, PWR_DIV4, PWR_DIV8, PWR_STOP} mcyc_pwr_t;
    typedef enum logic {ST_IDLE, ST_RUN} mcyc_state_t;
    typedef struct packed {
        logic [3:0] total;
        logic [3:0] csAct;
        logic [3:0] oeHalf;
        logic [3:0] rasAct;
        logic [3:0] casAct;
    } mcyc_tim_t;
endpackage

// File: mcyc_clk_div.sv
// enable divider: period tick and mid-period tick for half-period resolution
`timescale 1ns/1ps
module mcyc_clk_div #(
    parameter int W = 4
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic         en,
    input  wire logic [W-1:0] divisor,
    output logic              tick,
    output logic              mid
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic [W-1:0] half;
    logic         last;

    // last count of the period; a divisor of zero acts as one
    assign last  = (cnt_q + W'(1)) >= divisor;
    assign cnt_d = last ? '0 : cnt_q + W'(1);
    assign half  = divisor >> 1;
    assign tick  = en && last;
    assign mid   = en && (divisor > W'(1)) && (cnt_q == half - W'(1));

    // count enabled events only
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (en) begin
            cnt_q <= cnt_d;
        end
    end
endmodule

// File: mcyc_timing.sv
// memory cycle sequencer, clock division and configuration registers
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "mcyc_regs.svh"
module mcyc_timing
    import mcyc_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic      [7:0] regRdata,
    input  wire logic       cpuReq,
    input  wire logic       cpuWr,
    output logic            cpuAck,
    input  wire logic       dispReq,
    output logic            dispAck,
    output logic            memCsN,
    output logic            memOeN,
    output logic            memWeN,
    output logic            memCasN,
    output logic            procClkEn,
    output logic            ioClkEn
);
    logic [7:0]  clkReg_q;
    logic [7:0]  memCfg_q;
    logic [7:0]  pwrReg_q;
    logic [7:0]  dispCfg_q;
    logic [7:0]  regRdata_q;
    mcyc_state_t st_q;
    mcyc_state_t st_d;
    logic [4:0]  cnt_q;
    logic [4:0]  cnt_d;
    mcyc_tim_t   tim_q;
    mcyc_tim_t   timNext;
    mcyc_tim_t   timSel;
    logic        srcDisp_q;
    logic        wr_q;
    logic        dram_q;
    logic        memCsN_q;
    logic        memOeN_q;
    logic        memWeN_q;
    logic        memCasN_q;
    logic        cpuAck_q;
    logic        dispAck_q;
    logic        procClkEn_q;
    logic        ioClkEn_q;

    // lookup of one cycle's timing from width and cycle type
    function automatic mcyc_tim_t timOf(input logic w16, input mcyc_cyc_t cyc);
        mcyc_tim_t t;
        t = mcyc_tim_t'(`MCYC_T_X8_SLOW);
        unique case ({w16, cyc})
            {1'b0, CYC_FAST}:   t = mcyc_tim_t'(`MCYC_T_X8_FAST);
            {1'b0, CYC_NORMAL}: t = mcyc_tim_t'(`MCYC_T_X8_NORM);
            {1'b1, CYC_FAST}:   t = mcyc_tim_t'(`MCYC_T_X16_FAST);
            {1'b1, CYC_NORMAL}: t = mcyc_tim_t'(`MCYC_T_X16_NORM);
            {1'b1, CYC_SLOW},
            {1'b1, CYC_RSVD}:   t = mcyc_tim_t'(`MCYC_T_X16_SLOW);
            default:            t = mcyc_tim_t'(`MCYC_T_X8_SLOW);
        endcase
        return t;
    endfunction

    // processor divide code to divisor of the base clock
    function automatic logic [3:0] cpuDivOf(input logic [2:0] code);
        logic [3:0] d;
        d = `MCYC_CPUDIV_4;
        unique case (code)
            3'h0:    d = `MCYC_CPUDIV_0;
            3'h1:    d = `MCYC_CPUDIV_1;
            3'h2:    d = `MCYC_CPUDIV_2;
            3'h3:    d = `MCYC_CPUDIV_3;
            default: d = `MCYC_CPUDIV_4;
        endcase
        return d;
    endfunction

    // register field decode
    wire        wrClk     = regWr && (regAddr == `MCYC_IDX_CLK);
    wire        wrMemCfg  = regWr && (regAddr == `MCYC_IDX_MEMCFG);
    wire        wrPwr     = regWr && (regAddr == `MCYC_IDX_PWR);
    wire        wrDispCfg = regWr && (regAddr == `MCYC_IDX_DISPCFG);
    wire mcyc_cyc_t cycType = mcyc_cyc_t'(dispCfg_q[`MCYC_CYC_MSB:`MCYC_CYC_LSB]);
    wire mcyc_mem_t memType = mcyc_mem_t'(memCfg_q[`MCYC_MTYPE_MSB:`MCYC_MTYPE_LSB]);
    wire mcyc_pwr_t pwrMode = mcyc_pwr_t'(pwrReg_q[`MCYC_PWR_MSB:`MCYC_PWR_LSB]);
    wire        bus16     = memCfg_q[`MCYC_W16_BIT];
    wire        memClkCpu = memCfg_q[`MCYC_MCLK_BIT];
    wire [3:0]  cpuDiv    = cpuDivOf(clkReg_q[`MCYC_CPUDIV_MSB:`MCYC_CPUDIV_LSB]);
    wire [3:0]  ioDiv     = {2'h0, clkReg_q[`MCYC_IODIV_MSB:`MCYC_IODIV_LSB]} + 4'h1;
    wire [3:0]  psDiv     = (pwrMode == PWR_DIV4) ? `MCYC_PS4_DIV : `MCYC_PS8_DIV;

    // register writes; cycle type steers the sequencer
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            clkReg_q  <= `MCYC_RST_VAL;
            memCfg_q  <= `MCYC_RST_VAL;
            pwrReg_q  <= `MCYC_RST_VAL;
            dispCfg_q <= `MCYC_RST_VAL;
        end else begin
            if (wrClk) clkReg_q <= regWdata;
            if (wrMemCfg) memCfg_q <= regWdata;
            if (wrPwr) pwrReg_q <= regWdata;
            if (wrDispCfg) dispCfg_q <= regWdata;
        end
    end

    // read mux; unmapped indices read as zero
    wire [7:0] statVal = {1'b0, srcDisp_q, st_q == ST_RUN, cnt_q};
    wire [7:0] rdMux   = (regAddr == `MCYC_IDX_CLK)     ? clkReg_q  :
                         (regAddr == `MCYC_IDX_MEMCFG)  ? memCfg_q  :
                         (regAddr == `MCYC_IDX_PWR)     ? pwrReg_q  :
                         (regAddr == `MCYC_IDX_STAT)    ? statVal   :
                         (regAddr == `MCYC_IDX_DISPCFG) ? dispCfg_q : 8'h00;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            regRdata_q <= 8'h00;
        end else begin
            regRdata_q <= regRd ? rdMux : 8'h00;
        end
    end

    // clock enables: video at base/2, processor at base/N, power prescale, channel
    logic vidTick;
    logic vidMid;
    logic cpuTick;
    logic cpuMid;
    logic psTick;
    logic ioTick;

    mcyc_clk_div #(.W(4)) u_vid (
        .clock   (clock),
        .rst     (rst),
        .en      (1'b1),
        .divisor (`MCYC_VID_DIV),
        .tick    (vidTick),
        .mid     (vidMid)
    );

    mcyc_clk_div #(.W(4)) u_cpu (
        .clock   (clock),
        .rst     (rst),
        .en      (1'b1),
        .divisor (cpuDiv),
        .tick    (cpuTick),
        .mid     (cpuMid)
    );

    mcyc_clk_div #(.W(4)) u_ps (
        .clock   (clock),
        .rst     (rst),
        .en      (cpuTick),
        .divisor (psDiv),
        .tick    (psTick),
        .mid     ()
    );

    // slowed or stopped processor rate
    wire procTick = (pwrMode == PWR_FULL) ? cpuTick :
                    (pwrMode == PWR_STOP) ? 1'b0 : psTick;

    mcyc_clk_div #(.W(4)) u_io (
        .clock   (clock),
        .rst     (rst),
        .en      (procTick),
        .divisor (ioDiv),
        .tick    (ioTick),
        .mid     ()
    );

    // memory clock: video or processor period, chosen by the memory clock bit of the memory config
    wire memTick  = memClkCpu ? cpuTick : vidTick;
    wire halfTick = memTick | (memClkCpu ? cpuMid : vidMid);

    // requests; an acknowledged requester is masked for one cycle
    wire dispEff  = dispReq && !dispAck_q;
    wire cpuEff   = cpuReq && !cpuAck_q;
    wire startCyc = (st_q == ST_IDLE) && memTick && (dispEff || cpuEff);
    wire [4:0] totHalf = {tim_q.total, 1'b0};
    wire lastHalf = (st_q == ST_RUN) && halfTick && (cnt_q == totHalf - 5'h01);

    assign timSel  = timOf(bus16, cycType);
    assign timNext = startCyc ? timSel : tim_q;

    // sequencer state
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE: if (startCyc) st_d = ST_RUN;
            ST_RUN:  if (lastHalf) st_d = ST_IDLE;
        endcase
    end

    // half-period counter within a cycle
    assign cnt_d = startCyc ? 5'h00 :
                   lastHalf ? 5'h00 :
                   ((st_q == ST_RUN) && halfTick) ? cnt_q + 5'h01 : cnt_q;

    wire runD    = (st_d == ST_RUN);
    wire dramD   = startCyc ? (memType == MEM_DRAM) : dram_q;
    wire wrD     = startCyc ? (!dispEff && cpuWr) : wr_q;
    wire [4:0] csHalf  = dramD ? {timNext.rasAct, 1'b0} : {timNext.csAct, 1'b0};
    wire [4:0] oeEnd   = `MCYC_OE_START + {1'b0, timNext.oeHalf};
    wire [4:0] casEnd  = `MCYC_CAS_START + {timNext.casAct, 1'b0};
    wire csOn    = runD && (cnt_d < csHalf);
    wire strOn   = runD && (cnt_d >= `MCYC_OE_START) && (cnt_d < oeEnd);
    wire casOn   = runD && dramD && (cnt_d >= `MCYC_CAS_START) && (cnt_d < casEnd);

    // cycle context latched at start so cycle type, width and memory type changes wait for the next cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_q      <= ST_IDLE;
            cnt_q     <= 5'h00;
            tim_q     <= '0;
            srcDisp_q <= 1'b0;
            wr_q      <= 1'b0;
            dram_q    <= 1'b0;
        end else begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
            if (startCyc) begin
                tim_q     <= timSel;
                srcDisp_q <= dispEff;
                wr_q      <= wrD;
                dram_q    <= dramD;
            end
        end
    end

    // registered strobes, acknowledges and clock enables
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            memCsN_q    <= 1'b1;
            memOeN_q    <= 1'b1;
            memWeN_q    <= 1'b1;
            memCasN_q   <= 1'b1;
            cpuAck_q    <= 1'b0;
            dispAck_q   <= 1'b0;
            procClkEn_q <= 1'b0;
            ioClkEn_q   <= 1'b0;
        end else begin
            memCsN_q    <= !csOn;
            memOeN_q    <= !(strOn && !wrD);
            memWeN_q    <= !(strOn && wrD);
            memCasN_q   <= !casOn;
            cpuAck_q    <= lastHalf && !srcDisp_q;
            dispAck_q   <= lastHalf && srcDisp_q;
            procClkEn_q <= procTick;
            ioClkEn_q   <= ioTick;
        end
    end

    assign regRdata  = regRdata_q;
    assign cpuAck    = cpuAck_q;
    assign dispAck   = dispAck_q;
    assign memCsN    = memCsN_q;
    assign memOeN    = memOeN_q;
    assign memWeN    = memWeN_q;
    assign memCasN   = memCasN_q;
    assign procClkEn = procClkEn_q;
    assign ioClkEn   = ioClkEn_q;

    // checks on the running design
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_len;
        lastHalf |-> (cnt_q == {tim_q.total, 1'b0} - 5'h01) ##1 (cpuAck_q || dispAck_q);
    endproperty
    a_len: assert property (p_len) else $error("cycle end not acknowledged");

    property p_cs;
        (st_q == ST_RUN) && !dram_q |-> (memCsN_q == (cnt_q >= {tim_q.csAct, 1'b0}));
    endproperty
    a_cs: assert property (p_cs) else $error("chip select window wrong");

    property p_oe;
        !memOeN_q |-> (st_q == ST_RUN) && !wr_q && (cnt_q >= `MCYC_OE_START)
                      && (cnt_q <= {1'b0, tim_q.oeHalf});
    endproperty
    a_oe: assert property (p_oe) else $error("output enable outside window");

    property p_cyc;
        wrDispCfg |=> (dispCfg_q[`MCYC_CYC_MSB:`MCYC_CYC_LSB]
                       == $past(regWdata[`MCYC_CYC_MSB:`MCYC_CYC_LSB]));
    endproperty
    a_cyc: assert property (p_cyc) else $error("cycle type not stored");

    property p_prio;
        startCyc && dispReq && !dispAck_q |=> srcDisp_q && (tim_q == $past(timSel));
    endproperty
    a_prio: assert property (p_prio) else $error("display fetch not served first");

    property p_stop;
        (pwrMode == PWR_STOP) && $past(pwrMode == PWR_STOP) |-> !procClkEn_q && !ioClkEn_q;
    endproperty
    a_stop: assert property (p_stop) else $error("processor clock runs while stopped");

    property p_io;
        ioClkEn_q |-> procClkEn_q;
    endproperty
    a_io: assert property (p_io) else $error("channel tick without processor tick");

    property p_cas;
        !memCasN_q |-> dram_q && (cnt_q >= `MCYC_CAS_START)
                       && (cnt_q < `MCYC_CAS_START + {tim_q.casAct, 1'b0});
    endproperty
    a_cas: assert property (p_cas) else $error("column strobe outside window");

    c_disp: cover property (dispAck_q);
    c_wr:   cover property (!memWeN_q ##[1:20] cpuAck_q);
    c_dram: cover property (!memCasN_q);
    c_stop: cover property (pwrMode == PWR_STOP);
endmodule

// File: mcyc_mem_model.sv
// behavioural external memory device that measures strobe activity
`timescale 1ns/1ps
module mcyc_mem_model (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       clr,
    input  wire logic       memCsN,
    input  wire logic       memOeN,
    input  wire logic       memWeN,
    input  wire logic       memCasN,
    output logic      [4:0] csLow,
    output logic      [4:0] oeLow,
    output logic      [4:0] weLow,
    output logic      [4:0] casLow,
    output logic      [4:0] csFalls
);
    logic csPrev;

    // count clocks each strobe is low and how often the select falls
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            {csLow, oeLow, weLow, casLow, csFalls} <= '0;
            csPrev <= 1'b1;
        end else if (clr) begin
            {csLow, oeLow, weLow, casLow, csFalls} <= '0;
            csPrev <= memCsN;
        end else begin
            csLow   <= csLow + 5'(!memCsN);
            oeLow   <= oeLow + 5'(!memOeN);
            weLow   <= weLow + 5'(!memWeN);
            casLow  <= casLow + 5'(!memCasN);
            csFalls <= csFalls + 5'(csPrev && !memCsN);
            csPrev  <= memCsN;
        end
    end
endmodule

// File: test_memory_cycle_timing_and_clock_divide.sv
// self-checking bench for the memory cycle timing and clock divide block
`timescale 1ns/1ps
`include "mcyc_regs.svh"
module test_memory_cycle_timing_and_clock_divide
    import mcyc_pkg::*;
;
    logic       clock, rst, regWr, regRd, cpuReq, cpuWr, dispReq, clr;
    logic [7:0] regAddr, regWdata, regRdata, r;
    logic       cpuAck, dispAck, memCsN, memOeN, memWeN, memCasN, procClkEn, ioClkEn;
    logic [4:0] csLow, oeLow, weLow, casLow, csFalls;
    int         num_errors, compares, s, cs;
    int         csT[2][3]  = '{'{2, 2, 3}, '{3, 3, 4}};
    int         rasT[2][3] = '{'{2, 2, 3}, '{2, 3, 3}};
    int         casT[2][3] = '{'{1, 1, 2}, '{1, 2, 2}};
    int         oeT[2][3]  = '{'{3, 3, 5}, '{5, 5, 7}};
    int         dv[8]      = '{2, 3, 4, 6, 8, 8, 8, 8};

    mcyc_timing u_mcyc_timing (.clock(clock), .rst(rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .cpuReq(cpuReq), .cpuWr(cpuWr), .cpuAck(cpuAck), .dispReq(dispReq),
        .dispAck(dispAck), .memCsN(memCsN), .memOeN(memOeN), .memWeN(memWeN),
        .memCasN(memCasN), .procClkEn(procClkEn), .ioClkEn(ioClkEn));

    mcyc_mem_model u_mcyc_mem_model (.clock(clock), .rst(rst), .clr(clr),
        .memCsN(memCsN), .memOeN(memOeN), .memWeN(memWeN), .memCasN(memCasN),
        .csLow(csLow), .oeLow(oeLow), .weLow(weLow), .casLow(casLow), .csFalls(csFalls));

    // 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clock);
        regWr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRd <= 1'b0;
        @(negedge clock);
        check(regRdata, exp);
    endtask

    // expected figures in half periods: total, select, output enable, column
    function automatic logic [7:0] ex(input int w, input int c, input int m, input int k);
        int t;
        case (k)
            0: t = 2 * (3 + w + c);
            1: t = 2 * ((m == 2) ? rasT[w][c] : csT[w][c]);
            2: t = oeT[w][c];
            default: t = (m == 2) ? 2 * casT[w][c] : 0;
        endcase
        return 8'(t);
    endfunction

    // one memory cycle on the video or processor clock, both base/2, half period equal to one clock
    task automatic cyc(input int w, input int c, input int m, input bit d, input bit cr,
                       input bit wt);
        int n;
        int cc;
        bit st;
        cc = (c > 2) ? 2 : c;
        n  = 0;
        st = 0;
        r  = 8'($urandom);
        wr(`MCYC_IDX_MEMCFG, {r[7:4], r[3], 2'(m), 1'(w)}); // processor clock is base/2 here too
        r  = 8'($urandom);
        wr(`MCYC_IDX_DISPCFG, {r[7], 2'(c), r[4:0]});
        @(posedge clock);
        clr <= 1'b1;
        @(posedge clock);
        clr     <= 1'b0;
        dispReq <= d;
        cpuReq  <= cr;
        cpuWr   <= wt;
        repeat (60) begin
            @(negedge clock);
            if (cpuAck === 1'b1 || dispAck === 1'b1)
                break;
            if (st || memCsN === 1'b0) begin
                st = 1;
                n++;
            end
        end
        check(8'(n), ex(w, cc, m, 0));
        check(8'(dispAck), 8'(d));
        check(8'(csLow), ex(w, cc, m, 1));
        check(8'(oeLow), (d || !wt) ? ex(w, cc, m, 2) : 8'h00);
        check(8'(weLow), (!d && wt) ? ex(w, cc, m, 2) : 8'h00);
        check(8'(casLow), ex(w, cc, m, 3));
        check(8'(csFalls), 8'h01);
        @(posedge clock);
        dispReq <= 1'b0;
        if (!(d && cr))
            cpuReq <= 1'b0;
        if (d && cr) begin
            repeat (60) begin
                @(negedge clock);
                if (cpuAck === 1'b1)
                    break;
            end
            check(8'(cpuAck), 8'h01);
            @(posedge clock);
            cpuReq <= 1'b0;
        end
    endtask

    // clocks between two enable pulses
    task automatic gap(input bit io, output int n);
        n = 0;
        repeat (300) begin
            @(negedge clock);
            if ((io ? ioClkEn : procClkEn) === 1'b1)
                break;
        end
        if (io)
            check(8'(procClkEn), 8'h01);
        repeat (300) begin
            @(negedge clock);
            n++;
            if ((io ? ioClkEn : procClkEn) === 1'b1)
                break;
        end
    endtask

    task automatic clk(input int c, input int p, input int i, input bit io, input int e);
        int n;
        wr(`MCYC_IDX_CLK, {3'(c), 3'b000, 2'(i)});
        wr(`MCYC_IDX_PWR, {6'h00, 2'(p)});
        gap(io, n);
        gap(io, n);
        check(8'(n), 8'(e));
    endtask

    // watchdog against a hung handshake
    initial begin
        #400000;
        num_errors++;
        complete_run;
    end

    // main sequence
    initial begin
        {regWr, regRd, cpuReq, cpuWr, dispReq, clr} = '0;
        regAddr  = 8'h00;
        regWdata = 8'h00;
        rst      = 1'b1;
        void'($urandom(66037));
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        foreach (dv[k])
            rd(8'(k), 8'h00);
        wr(8'h05, 8'hFF);
        rd(8'h05, 8'h00);
        wr(`MCYC_IDX_STAT, 8'hFF);
        rd(`MCYC_IDX_STAT, 8'h00);
        r = 8'($urandom);
        wr(`MCYC_IDX_DISPCFG, r);
        rd(`MCYC_IDX_DISPCFG, r);
        for (int w = 0; w < 2; w++)
            for (int c = 0; c < 4; c++)
                for (int m = 0; m < 4; m++) begin
                    s = $urandom % 3;
                    cyc(w, c, m, s > 0, s != 1, 1'($urandom));
                end
        for (int c = 0; c < 8; c++)
            clk(c, 0, 0, 0, dv[c]);
        for (int p = 1; p < 3; p++) begin
            cs = $urandom % 5;
            clk(cs, p, 0, 0, dv[cs] * ((p == 1) ? 4 : 8));
        end
        wr(`MCYC_IDX_PWR, 8'h03);
        @(posedge clock); // a pulse launched by the last slowed tick may still stand
        s = 0;
        repeat (100) begin
            @(negedge clock);
            s += int'(procClkEn === 1'b1) + int'(ioClkEn === 1'b1);
        end
        check(8'(s), 8'h00);
        for (int i = 0; i < 4; i++) begin
            cs = $urandom % 5;
            clk(cs, 0, i, 1, dv[cs] * (i + 1));
        end
        complete_run;
    end
endmodule
